// ===== framer_model.sv
// Framer-side model: transmit data source, line loop-back and pattern error counter
`timescale 1ns/10ps

module framer_model (
    input wire logic clk, // Line clock
    input wire logic rst, // Async reset, high
    input wire line_ctrl_pkg::rail_s [1:0] tx_line_out, // Stream from the block
    input wire line_ctrl_pkg::rail_s [1:0] rx_data_out, // Recovered data and error flag
    input wire logic [1:0] loop_on, // Feed the transmit stream back as line pulses
    input wire logic [1:0] flip, // Corrupt one looped bit
    input wire logic clr_cnt, // Clear the error counts
    output line_ctrl_pkg::rail_s [1:0] tx_data_in, // System transmit data
    output line_ctrl_pkg::rail_s [1:0] rx_line_in, // Line pulses to the block
    output logic [1:0][15:0] err_cnt // Pattern errors seen per lane
);
    logic [7:0] cnt;

    // Data follows a free-running counter so a stale or stuck path cannot match by luck
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 8'h00;
            tx_data_in <= '0;
            rx_line_in <= '0;
            err_cnt <= '0;
        end else begin
            cnt <= cnt + 8'h01;
            for (int i = 0; i < 2; i++) begin
                tx_data_in[i].pos <= cnt[0] ^ cnt[i+2];
                tx_data_in[i].neg <= cnt[1];
                rx_line_in[i].pos <= loop_on[i] ? (tx_line_out[i].pos ^ flip[i]) : (cnt[0] ^ cnt[3]);
                rx_line_in[i].neg <= loop_on[i] ? 1'b0 : (cnt[2] & ~cnt[0]);
                err_cnt[i] <= clr_cnt ? 16'h0000 : err_cnt[i] + 16'(rx_data_out[i].neg);
            end
        end
    end
endmodule

// ===== line_ctrl.sv
// Per-lane line control register bank with loop-back, rail mode and PRBS test
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "line_ctrl_defs.svh"

// Overview of operation
// - DS3 or STS-1 pattern is 2^15-1
// - E3 pattern is 2^23-1
// - Checker searches recovered data when enabled
// - Bit 5 enables generator and checker together
// - Single rail: negative output flags pattern errors
// - Pattern replaces system transmit data
// - Pattern test only under host control
// - Loop bits 00 normal, remote bit remote loop
// - Local only gives analog local loop
// - Both bits give digital local loop
// - Rate bit 2 forces E3
// - Bit 2 clear: DS3 or STS-1
// - Bit 1 picks STS-1, ignored in E3
// - Single rail enables line coder, one data rail; remote loop still passes both received rails to the line
// - Dual rail pulses one period per line pulse

module line_ctrl #(
    parameter int LANES = 2,
    parameter int PRBS_WIDTH = `PRBS23_LEN
) (
    input wire logic clk, // 40 MHz clock
    input wire logic rst, // Async reset, high
    input wire logic [7:0] addr, // Register address
    input wire logic [7:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [7:0] rdata, // Read data, cycle after rd
    output logic irq, // Level interrupt
    input wire logic host_mode, // 1 when driven by host registers
    input wire line_ctrl_pkg::rail_s [LANES-1:0] tx_data_in, // tx_positive/negative_data_in
    input wire line_ctrl_pkg::rail_s [LANES-1:0] rx_line_in, // Recovered line pulses
    output line_ctrl_pkg::rail_s [LANES-1:0] tx_line_out, // To line driver
    output line_ctrl_pkg::rail_s [LANES-1:0] rx_data_out, // rx_positive_data_out, neg/violation
    output logic [LANES-1:0] coder_enable, // Line coder on
    output line_ctrl_pkg::rate_e [LANES-1:0] rate, // Line rate in effect
    output line_ctrl_pkg::loop_e [LANES-1:0] loop_mode // Loop-back in effect
);
    // Refused at elaboration: offsets and status bits exist for two lanes only
    if (LANES < 1 || LANES > 2) begin : g_bad_lanes
        $error("line_ctrl supports one or two lanes");
    end

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        line_ctrl_pkg::ctrl_s [LANES-1:0] ctrl;
        logic [7:0] irq_status;
        logic [7:0] irq_mask;
        logic [7:0] rdata;
        line_ctrl_pkg::rail_s [LANES-1:0] tx_out;
        line_ctrl_pkg::rail_s [LANES-1:0] rx_out;
        logic [LANES-1:0] lock_d;
    } state_s;

    state_s state;
    state_s next_state;

    logic [LANES-1:0] gen_bit;
    logic [LANES-1:0] chk_err;
    logic [LANES-1:0] chk_lock;
    logic [LANES-1:0] pat_on;
    logic [LANES-1:0] e3;
    logic [LANES-1:0] chk_in;
    logic [7:0] events;

    // --------------------------------------------------------------
    // Pattern engines per lane
    // --------------------------------------------------------------
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        // Outside host control the pattern logic is held off.
        assign pat_on[i] = state.ctrl[i].pattern_en & host_mode;
        assign e3[i] = state.ctrl[i].rate_e3_select;

        prbs_gen #(.WIDTH(PRBS_WIDTH)) u_gen (
            .clk(clk),
            .rst(rst),
            .enable(pat_on[i]),
            .long_mode(e3[i]),
            .bit_out(gen_bit[i])
        );

        // Digital local loop feeds the checker from the transmit stream.
        assign chk_in[i] = (loop_mode[i] == line_ctrl_pkg::LOOP_DIGITAL) ?
                           state.tx_out[i].pos : rx_line_in[i].pos;

        prbs_chk #(.WIDTH(PRBS_WIDTH)) u_chk (
            .clk(clk),
            .rst(rst),
            .enable(pat_on[i]),
            .long_mode(e3[i]),
            .data_in(chk_in[i]),
            .error(chk_err[i]),
            .locked(chk_lock[i])
        );

        always_comb begin
            if (state.ctrl[i].rate_e3_select) begin
                rate[i] = line_ctrl_pkg::RATE_E3;
            end else if (state.ctrl[i].sonet_or_t3_rate_select) begin
                rate[i] = line_ctrl_pkg::RATE_STS1;
            end else begin
                rate[i] = line_ctrl_pkg::RATE_DS3;
            end
            unique case ({state.ctrl[i].local_loop_select, state.ctrl[i].remote_loop_select})
                2'b00: loop_mode[i] = line_ctrl_pkg::LOOP_NONE;
                2'b01: loop_mode[i] = line_ctrl_pkg::LOOP_REMOTE;
                2'b10: loop_mode[i] = line_ctrl_pkg::LOOP_ANALOG;
                2'b11: loop_mode[i] = line_ctrl_pkg::LOOP_DIGITAL;
            endcase
        end

        assign coder_enable[i] = ~state.ctrl[i].rail_mode_select;
        assign tx_line_out[i] = state.tx_out[i];
        assign rx_data_out[i] = state.rx_out[i];
    end

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        next_state = state;
        events = 8'h00;
        next_state.rdata = 8'h00;

        for (int i = 0; i < LANES; i++) begin
            // Transmit path
            if (pat_on[i]) begin
                next_state.tx_out[i].pos = gen_bit[i];
                next_state.tx_out[i].neg = 1'b0;
            end else if (loop_mode[i] == line_ctrl_pkg::LOOP_REMOTE) begin
                next_state.tx_out[i] = rx_line_in[i];
            end else if (!state.ctrl[i].rail_mode_select) begin
                next_state.tx_out[i].pos = tx_data_in[i].pos;
                next_state.tx_out[i].neg = 1'b0;
            end else begin
                next_state.tx_out[i] = tx_data_in[i];
            end

            // Receive path; analog and digital local loops return transmit data to the system side
            if (loop_mode[i] == line_ctrl_pkg::LOOP_ANALOG ||
                loop_mode[i] == line_ctrl_pkg::LOOP_DIGITAL) begin
                next_state.rx_out[i] = state.tx_out[i];
            end else begin
                next_state.rx_out[i] = rx_line_in[i];
            end
            if (!state.ctrl[i].rail_mode_select) begin
                // Single rail: negative output carries the error flag only
                // while checking; no counter here, framer logic counts.
                next_state.rx_out[i].neg = pat_on[i] & chk_err[i];
            end

            next_state.lock_d[i] = chk_lock[i];
            events[2*i] = chk_err[i];
            events[2*i+1] = chk_lock[i] & ~state.lock_d[i];
        end

        // Register writes
        if (wr) begin
            for (int i = 0; i < LANES; i++) begin
                if (addr == (i == 0 ? `LANE0_LINE_CONTROL_OFS : `LANE1_LINE_CONTROL_OFS)) begin
                    next_state.ctrl[i] = 6'(wdata & `LINE_CONTROL_WMASK);
                end
            end
            if (addr == `IRQ_MASK_OFS) begin
                next_state.irq_mask = wdata;
            end
        end

        // Sticky status: a new event beats a write-one clear
        next_state.irq_status = state.irq_status;
        if (wr && addr == `IRQ_STATUS_OFS) begin
            next_state.irq_status = state.irq_status & ~wdata;
        end
        next_state.irq_status = next_state.irq_status | events;

        // Register reads
        if (rd) begin
            for (int i = 0; i < LANES; i++) begin
                if (addr == (i == 0 ? `LANE0_LINE_CONTROL_OFS : `LANE1_LINE_CONTROL_OFS)) begin
                    next_state.rdata = {2'b00, state.ctrl[i]};
                end
            end
            if (addr == `IRQ_STATUS_OFS) begin
                next_state.rdata = state.irq_status;
            end
            if (addr == `IRQ_MASK_OFS) begin
                next_state.rdata = state.irq_mask;
            end
            if (addr == `LINE_STATUS_OFS) begin
                next_state.rdata = 8'({chk_lock, pat_on});
            end
        end
    end

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;
    assign irq = |(state.irq_status & state.irq_mask);

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_upper_bits_zero: assert property (
        rd && addr == `LANE0_LINE_CONTROL_OFS |=> rdata[7:6] == 2'b00)
        else $error("control bits 7:6 not zero");
    a_ctrl_write_read: assert property (
        wr && addr == `LANE0_LINE_CONTROL_OFS ##1 !wr && !rd
        ##1 rd && addr == `LANE0_LINE_CONTROL_OFS
        |=> rdata == (($past(wdata, 3)) & `LINE_CONTROL_WMASK))
        else $error("control readback mismatch");
    a_e3_rate: assert property (
        state.ctrl[0].rate_e3_select |-> rate[0] == line_ctrl_pkg::RATE_E3)
        else $error("E3 bit did not force E3");
    a_sts1_rate: assert property (
        !state.ctrl[0].rate_e3_select && state.ctrl[0].sonet_or_t3_rate_select
        |-> rate[0] == line_ctrl_pkg::RATE_STS1)
        else $error("STS-1 not selected");
    a_digital_loop: assert property (
        state.ctrl[0].local_loop_select && state.ctrl[0].remote_loop_select
        |-> loop_mode[0] == line_ctrl_pkg::LOOP_DIGITAL)
        else $error("digital loop not entered");
    a_remote_loop: assert property (
        !state.ctrl[0].local_loop_select && state.ctrl[0].remote_loop_select
        |-> loop_mode[0] == line_ctrl_pkg::LOOP_REMOTE)
        else $error("remote loop not entered");
    a_pattern_tx: assert property (
        pat_on[0] |=> tx_line_out[0].pos == $past(gen_bit[0]) && !tx_line_out[0].neg)
        else $error("system data not replaced by pattern");
    a_error_pin: assert property (
        !state.ctrl[0].rail_mode_select && $past(!state.ctrl[0].rail_mode_select)
        |-> rx_data_out[0].neg == ($past(pat_on[0]) && $past(chk_err[0])))
        else $error("error flag not on negative output");
    a_host_only: assert property (
        !host_mode |=> $stable(gen_bit[0]) && !chk_lock[0])
        else $error("pattern logic running without host control");
    a_single_rail_tx: assert property (
        !state.ctrl[0].rail_mode_select && loop_mode[0] != line_ctrl_pkg::LOOP_REMOTE
        |=> !tx_line_out[0].neg)
        else $error("negative transmit rail not idle in single rail");
    a_error_sticky: assert property (
        chk_err[0] |=> state.irq_status[0])
        else $error("error event did not set status");

    c_pattern_lock: cover property (pat_on[0] ##1 chk_lock[0]);
    c_pattern_error: cover property (chk_lock[0] && chk_err[0]);
    c_e3_pattern: cover property (pat_on[0] && e3[0]);
    c_irq_raised: cover property (!irq ##1 irq);
endmodule

// ===== line_ctrl_defs.svh
// Register offsets, field positions, reset values and PRBS constants
`ifndef LINE_CTRL_DEFS_SVH
`define LINE_CTRL_DEFS_SVH

`define LANE0_LINE_CONTROL_OFS 8'h06
`define LANE1_LINE_CONTROL_OFS 8'h0E
`define IRQ_STATUS_OFS 8'h20
`define IRQ_MASK_OFS 8'h21
`define LINE_STATUS_OFS 8'h22
`define LINE_CONTROL_RESET 8'h00
`define LINE_CONTROL_WMASK 8'h3F
`define BIT_RAIL 0
`define BIT_STS1 1
`define BIT_E3 2
`define BIT_LOCAL_LOOP 3
`define BIT_REMOTE_LOOP 4
`define BIT_PATTERN_EN 5
`define PRBS15_LEN 15
`define PRBS15_TAP 14
`define PRBS23_LEN 23
`define PRBS23_TAP 18
`define SYNC_GOOD_COUNT 5'd24
`define SYNC_BAD_COUNT 3'd4

`endif

// ===== line_ctrl_pkg.sv
// Types shared by the line control block
package line_ctrl_pkg;

    typedef enum logic [1:0] {RATE_DS3, RATE_STS1, RATE_E3} rate_e;
    typedef enum logic [1:0] {LOOP_NONE, LOOP_REMOTE, LOOP_ANALOG, LOOP_DIGITAL} loop_e;

    typedef struct packed {
        logic pattern_en;
        logic remote_loop_select;
        logic local_loop_select;
        logic rate_e3_select;
        logic sonet_or_t3_rate_select;
        logic rail_mode_select;
    } ctrl_s;

    typedef struct packed {
        logic pos;
        logic neg;
    } rail_s;

endpackage

// ===== prbs_chk.sv
// PRBS checker: self-synchronising per-bit error detection
`timescale 1ns/10ps
`include "line_ctrl_defs.svh"

module prbs_chk #(
    parameter int WIDTH = `PRBS23_LEN
) (
    input wire logic clk, // Line clock
    input wire logic rst, // Async reset, high
    input wire logic enable, // Checker running
    input wire logic long_mode, // 1 selects the 23-stage sequence
    input wire logic data_in, // Recovered data bit
    output logic error, // Registered per-bit error
    output logic locked // Sequence found
);
    // Refused at elaboration: the long sequence needs every stage
    if (WIDTH < `PRBS23_LEN) begin : g_bad_width
        $error("prbs_chk WIDTH too small");
    end

    typedef struct packed {
        logic [WIDTH-1:0] hist;
        logic [4:0] good;
        logic [2:0] bad;
        logic locked;
        logic error;
    } state_s;

    state_s state;
    state_s next_state;
    logic expect_bit;
    logic miss;

    // Expected bit is predicted from the last received bits, so the search
    // restarts by itself after any slip without a separate seeding phase.
    always_comb begin
        next_state = state;
        expect_bit = long_mode ? (state.hist[`PRBS23_LEN-1] ^ state.hist[`PRBS23_TAP-1])
                               : (state.hist[`PRBS15_LEN-1] ^ state.hist[`PRBS15_TAP-1]);
        miss = expect_bit ^ data_in;
        next_state.error = 1'b0;
        if (!enable) begin
            next_state.good = '0;
            next_state.bad = '0;
            next_state.locked = 1'b0;
        end else begin
            next_state.hist = {state.hist[WIDTH-2:0], data_in};
            next_state.error = miss & state.locked;
            if (!state.locked) begin
                next_state.good = miss ? 5'd0 : state.good + 5'd1;
                if (!miss && state.good == `SYNC_GOOD_COUNT - 5'd1) begin
                    next_state.locked = 1'b1;
                    next_state.bad = '0;
                end
            end else if (miss) begin
                next_state.bad = state.bad + 3'd1;
                if (state.bad == `SYNC_BAD_COUNT - 3'd1) begin
                    next_state.locked = 1'b0;
                    next_state.good = '0;
                end
            end else begin
                next_state.bad = '0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '{hist: '0, good: 5'd0, bad: 3'd0, locked: 1'b0, error: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign error = state.error;
    assign locked = state.locked;
endmodule

// ===== prbs_gen.sv
// PRBS generator: 2^15-1 or 2^23-1 sequence, one bit per clock
`timescale 1ns/10ps
`include "line_ctrl_defs.svh"

module prbs_gen #(
    parameter int WIDTH = `PRBS23_LEN
) (
    input wire logic clk, // Line clock
    input wire logic rst, // Async reset, high
    input wire logic enable, // Step the sequence
    input wire logic long_mode, // 1 selects the 23-stage sequence
    output logic bit_out // Generated bit
);
    // Refused at elaboration: the long sequence needs every stage
    if (WIDTH < `PRBS23_LEN) begin : g_bad_width
        $error("prbs_gen WIDTH too small");
    end

    typedef struct packed {
        logic [WIDTH-1:0] lfsr;
        logic out;
    } state_s;

    state_s state;
    state_s next_state;
    logic fb;

    always_comb begin
        next_state = state;
        fb = long_mode ? (state.lfsr[`PRBS23_LEN-1] ^ state.lfsr[`PRBS23_TAP-1])
                       : (state.lfsr[`PRBS15_LEN-1] ^ state.lfsr[`PRBS15_TAP-1]);
        if (enable) begin
            next_state.lfsr = {state.lfsr[WIDTH-2:0], fb};
            next_state.out = fb;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '{lfsr: '1, out: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign bit_out = state.out;
endmodule

// ===== test_line_ctrl.sv
// Self-checking testbench of the line control register bank
`timescale 1ns/10ps
`include "line_ctrl_defs.svh"

module test_line_ctrl;
    logic clk, rst, wr, rd, irq, host_mode, clr_cnt;
    logic [7:0] addr, wdata, rdata;
    logic [1:0] coder_enable, loop_on, flip;
    logic [1:0][15:0] err_cnt;
    line_ctrl_pkg::rail_s [1:0] tx_data_in, rx_line_in, tx_line_out, rx_data_out;
    line_ctrl_pkg::rate_e [1:0] rate;
    line_ctrl_pkg::loop_e [1:0] loop_mode;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;

    line_ctrl #(.LANES(2), .PRBS_WIDTH(`PRBS23_LEN)) line_ctrl_inst (.clk(clk), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .host_mode(host_mode), .tx_data_in(tx_data_in), .rx_line_in(rx_line_in),
        .tx_line_out(tx_line_out), .rx_data_out(rx_data_out), .coder_enable(coder_enable),
        .rate(rate), .loop_mode(loop_mode));
    framer_model framer_model_inst (.clk(clk), .rst(rst), .tx_line_out(tx_line_out),
        .rx_data_out(rx_data_out), .loop_on(loop_on), .flip(flip), .clr_cnt(clr_cnt),
        .tx_data_in(tx_data_in), .rx_line_in(rx_line_in), .err_cnt(err_cnt));

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (exp !== got) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(what, {8'h00, exp}, {8'h00, rdata});
    endtask

    task automatic pulse_in(input bit sel);
        @(posedge clk);
        if (sel) flip <= 2'b01;
        else clr_cnt <= 1'b1;
        @(posedge clk);
        flip <= 2'b00;
        clr_cnt <= 1'b0;
    endtask

    // Outputs are registered: each compares against the previous cycle's input, or in local loop the previous transmit output.
    // Mode 0 normal, 1 remote loop, 2 local loop, 3 single rail.
    task automatic stream_chk(input int l, input int mode);
        line_ctrl_pkg::rail_s ptx, prx, ptl;
        int bad;
        bad = 0;
        repeat (3) @(negedge clk);
        for (int k = 0; k < 20; k++) begin
            ptx = tx_data_in[l];
            prx = rx_line_in[l];
            ptl = tx_line_out[l];
            @(negedge clk);
            if (mode == 1) bad += (tx_line_out[l] !== prx);
            else if (mode == 2) bad += (rx_data_out[l] !== ptl);
            else if (mode == 3) bad += (tx_line_out[l] !== {ptx.pos, 1'b0}) +
                (rx_data_out[l] !== {prx.pos, 1'b0});
            else bad += (tx_line_out[l] !== ptx) + (rx_data_out[l] !== prx);
        end
        chk("stream", 16'h0000, 16'(bad));
    endtask

    // Either tap convention of the same polynomial gives a maximal sequence
    task automatic prbs_test(input int l, input int len, input int tap);
        logic q [0:79];
        int m1, m2, ones;
        m1 = 0;
        m2 = 0;
        ones = 0;
        repeat (10) @(negedge clk);
        for (int k = 0; k < 80; k++) begin
            @(negedge clk);
            q[k] = tx_line_out[l].pos;
        end
        for (int k = len; k < 80; k++) begin
            m1 += (q[k] !== (q[k-len] ^ q[k-tap]));
            m2 += (q[k] !== (q[k-len] ^ q[k-len+tap]));
            ones += q[k];
        end
        chk("prbs", 16'h0000, 16'((m1 != 0 && m2 != 0) || ones == 0));
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] v;
        int l;
        rst = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        host_mode = 1'b1;
        loop_on = 2'b00;
        flip = 2'b00;
        clr_cnt = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk("lane0", `LANE0_LINE_CONTROL_OFS, `LINE_CONTROL_RESET);
        rd_chk("lane1", `LANE1_LINE_CONTROL_OFS, `LINE_CONTROL_RESET);
        rd_chk("mask", `IRQ_MASK_OFS, 8'h00);
        wr_reg(8'h30, 8'hFF);
        rd_chk("unmapped", 8'h30, 8'h00);
        wr_reg(`LANE0_LINE_CONTROL_OFS, 8'hFF);
        rd_chk("ctrl", `LANE0_LINE_CONTROL_OFS, 8'h3F);
        for (int i = 0; i < 32; i++) begin
            v = {3'b000, i[4:0]};
            l = i[4] ^ i[1];
            wr_reg(l ? `LANE1_LINE_CONTROL_OFS : `LANE0_LINE_CONTROL_OFS, v);
            repeat (2) @(negedge clk);
            chk("rate", {14'h0000, v[2] ? line_ctrl_pkg::RATE_E3 : (v[1] ?
                line_ctrl_pkg::RATE_STS1 : line_ctrl_pkg::RATE_DS3)}, {14'h0000, rate[l]});
            chk("loop", {14'h0000, v[3], v[4]}, {14'h0000, loop_mode[l]});
            chk("coder", {15'h0000, ~v[0]}, {15'h0000, coder_enable[l]});
            rd_chk("readback", l ? `LANE1_LINE_CONTROL_OFS : `LANE0_LINE_CONTROL_OFS, v);
        end
        wr_reg(`LANE0_LINE_CONTROL_OFS, 8'h01);
        wr_reg(`LANE1_LINE_CONTROL_OFS, 8'h01);
        stream_chk(0, 1'b0);
        stream_chk(1, 1'b0);
        wr_reg(`LANE0_LINE_CONTROL_OFS, 8'h11);
        stream_chk(0, 1'b1);
        wr_reg(`LANE0_LINE_CONTROL_OFS, 8'h09);
        stream_chk(0, 2);
        wr_reg(`LANE0_LINE_CONTROL_OFS, 8'h19);
        stream_chk(0, 2);
        wr_reg(`LANE1_LINE_CONTROL_OFS, 8'h00);
        stream_chk(1, 3);
        @(posedge clk);
        host_mode <= 1'b0;
        wr_reg(`LANE0_LINE_CONTROL_OFS, 8'h21);
        stream_chk(0, 1'b0);
        @(posedge clk);
        host_mode <= 1'b1;
        wr_reg(`LANE0_LINE_CONTROL_OFS, 8'h20);
        prbs_test(0, `PRBS15_LEN, `PRBS15_TAP);
        wr_reg(`LANE1_LINE_CONTROL_OFS, 8'h26);
        prbs_test(1, `PRBS23_LEN, `PRBS23_TAP);
        wr_reg(`LANE1_LINE_CONTROL_OFS, 8'h00);
        // Lane 0 pattern looped back through the framer model
        @(posedge clk);
        loop_on <= 2'b01;
        repeat (200) @(posedge clk);
        wr_reg(`IRQ_STATUS_OFS, 8'hFF);
        rd_chk("status", `IRQ_STATUS_OFS, 8'h00);
        rd_chk("line", `LINE_STATUS_OFS, 8'h05);
        pulse_in(1'b0);
        pulse_in(1'b1);
        repeat (60) @(posedge clk);
        chk("errors", 16'h0001, 16'(err_cnt[0] != 16'h0000));
        chk("irq", 16'h0000, {15'h0000, irq});
        rd_chk("status", `IRQ_STATUS_OFS, 8'h01);
        wr_reg(`IRQ_MASK_OFS, 8'h01);
        @(negedge clk);
        chk("irq", 16'h0001, {15'h0000, irq});
        wr_reg(`IRQ_STATUS_OFS, 8'h01);
        repeat (2) @(negedge clk);
        chk("irq", 16'h0000, {15'h0000, irq});
        rd_chk("status", `IRQ_STATUS_OFS, 8'h00);
        close_out();
    end
endmodule
